/* logic/bfc_pkg.sv */
// Constants, register map and types of the parallel flash host controller.
`default_nettype none
package bfc_pkg;
    // ----------------------------------------------------------------
    // Clock and pin timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    // Least times in ns, rounded up to whole clock cycles below.
    localparam int unsigned T_SETUP_NS = 10;
    localparam int unsigned T_WE_LOW_NS = 35;
    localparam int unsigned T_READ_NS = 150;
    localparam int unsigned T_HOLD_NS = 10;
    localparam int unsigned T_RESET_TO_OUTPUT_NS = 1000;
    localparam int unsigned T_RESET_TO_WRITE_NS = 1000;
    localparam int unsigned SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WE_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    // Read strobe also covers the three-stage input synchroniser.
    localparam int unsigned SYNC_LAT = 3;
    localparam int unsigned RD_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT;
    localparam int unsigned OUT_CYC = (T_RESET_TO_OUTPUT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WAKE_CYC = (T_RESET_TO_WRITE_NS * CLK_MHZ + 999) / 1000;
    // ----------------------------------------------------------------
    // Device geometry and pins
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 23;
    localparam int unsigned DQ_W = 16;
    localparam int unsigned BUF_WORDS = 16;
    localparam int unsigned READY_BIT = 7;
    localparam logic [2:0] CE_ON = 3'h0;
    localparam logic [2:0] CE_OFF = 3'h7;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_WDATA = 12'h008;
    localparam logic [11:0] OFF_OP = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_RDATA = 12'h014;
    localparam logic [11:0] OFF_BUF = 12'h040;
    localparam logic [11:0] BUF_MASK = 12'hfc0;
    // CTRL fields.
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_X16 = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // OP fields.
    localparam int unsigned OP_KIND_LSB = 0;
    localparam int unsigned OP_CNT_LSB = 4;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_BURST = 2'h2;
    localparam logic [1:0] OP_POLL = 2'h3;
    // STATUS fields.
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_LEVEL = 1;
    localparam int unsigned ST_PULSE = 2;
    localparam int unsigned ST_AWAKE = 3;
    typedef enum logic [1:0] {
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_HOLD
    } bfc_state_e;
endpackage
`default_nettype wire

/* logic/bfc_sync.sv */
// Three-stage input synchroniser that accepts a bit once stages two and three agree.
`default_nettype none
module bfc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                s1_reg[i] <= 1'b0;
                s2_reg[i] <= 1'b0;
                s3_reg[i] <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                s1_reg[i] <= din[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                if (s2_reg[i] == s3_reg[i]) begin
                    dout[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* logic/bfc_delay.sv */
// Counter that flags when its run input has been high for CYCLES clock cycles.
`default_nettype none
module bfc_delay #(
    parameter int unsigned CYCLES = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic run,
    output logic done
);
    logic [15:0] cnt_reg;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt_reg <= 16'h0000;
            done <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 16'h0000;
            done <= 1'b0;
        end else if (cnt_reg >= 16'(CYCLES - 1)) begin
            done <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* logic/bfc_host.sv */
// Host controller that drives a parallel block-erase flash through its pins.
`default_nettype none
// What this block does
// [R1] Device array is 128-Kbyte blocks, each erased on its own.
// [R2] Only valid command sequences written by the host start device automation.
// [R3] Device runs erase, program and lock algorithms alone once started.
// [R4] Erase can be suspended to read or program other blocks.
// [R5] Device write buffer holds 32 bytes or 16 words filled by host.
// [R6] Buffered programming writes the array a whole buffer at a time.
// [R7] A set block lock bit blocks erase and program of that block.
// [R8] A set master lock bit freezes the block lock bits.
// [R9] Lock operations: set block bit, set master bit, clear all block bits.
// [R10] Device status register reports when an operation has finished.
// [R11] Status output in level mode is low while the machine is busy.
// [R12] Status output is high when ready, suspended idle, or in reset.
// [R13] Status output can be set to pulse on program or erase completion.
// [R14] Three chip enables together select or deselect the device.
// [R15] Width select low gives x8; lowest address bit picks the byte.
// [R16] Width select high gives x16; address bit zero is unused.
// [R17] Deselected with reset pin high, the device is in standby.
// [R18] Reset pin low powers down the device and ignores writes.
// [R19] Reset pin low resets the state machine and clears status.
// [R20] Host waits the reset-to-output time before trusting reads.
// [R21] Host waits the reset-to-write time before issuing writes.
// [R22] Device leaves reset in array-read mode.
// [R23] Device latches address and data on the write strobe rising edge.
// [R24] Busy device floats low data bits; host polls ready bit seven.
// [R25] Selecting chip-enable combination is an implementation constant.
module bfc_host (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [22:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic [15:0] flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic [2:0] flash_ce,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_width_x16,
    output logic reset_powerdown_n,
    input wire logic status_output
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    bfc_pkg::bfc_state_e state_reg;
    logic [1:0] ctrl_reg;
    logic [22:0] cfg_addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [15:0] buf_mem [bfc_pkg::BUF_WORDS];
    logic [1:0] kind_reg;
    logic [3:0] last_reg;
    logic [3:0] idx_reg;
    logic [7:0] cnt_reg;
    logic pend_reg;
    logic pulse_seen_reg;
    logic sts_prev_reg;
    logic [16:0] pin_sync;
    logic sts_sync;
    logic out_done;
    logic wake_done;
    logic awake;
    logic busy;
    logic wr_access;
    logic rd_setup;
    logic is_write;
    logic mapped;
    logic [31:0] rd_value;

    // ----------------------------------------------------------------
    // Pin inputs and reset recovery
    // ----------------------------------------------------------------
    bfc_sync #(
        .WIDTH(17)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .din({status_output, flash_dq_in}),
        .dout(pin_sync)
    );
    assign sts_sync = pin_sync[16];

    bfc_delay #(
        .CYCLES(bfc_pkg::OUT_CYC)
    ) u_out_delay (
        .clock(clock),
        .reset(reset),
        .run(reset_powerdown_n),
        .done(out_done)
    );

    bfc_delay #(
        .CYCLES(bfc_pkg::WAKE_CYC)
    ) u_wake_delay (
        .clock(clock),
        .reset(reset),
        .run(reset_powerdown_n),
        .done(wake_done)
    );

    assign awake = out_done && wake_done; // [R20] [R21]
    assign busy = pend_reg || (state_reg != bfc_pkg::S_IDLE);
    assign is_write = (kind_reg == bfc_pkg::OP_WRITE) || (kind_reg == bfc_pkg::OP_BURST);

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign mapped = (paddr[11:2] <= bfc_pkg::OFF_RDATA[11:2])
        || ((paddr & bfc_pkg::BUF_MASK) == bfc_pkg::OFF_BUF);
    assign wr_access = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        rd_value = 32'h00000000;
        if ((paddr & bfc_pkg::BUF_MASK) == bfc_pkg::OFF_BUF) begin
            rd_value = {16'h0000, buf_mem[paddr[5:2]]};
        end else begin
            unique case (paddr)
                bfc_pkg::OFF_CTRL: rd_value = {30'h00000000, ctrl_reg};
                bfc_pkg::OFF_ADDR: rd_value = {9'h000, cfg_addr_reg};
                bfc_pkg::OFF_WDATA: rd_value = {16'h0000, wdata_reg};
                bfc_pkg::OFF_OP: rd_value = {24'h000000, last_reg, 2'h0, kind_reg};
                bfc_pkg::OFF_STATUS: rd_value = {28'h0000000, awake, pulse_seen_reg,
                    sts_sync, busy};
                bfc_pkg::OFF_RDATA: rd_value = {16'h0000, rdata_reg};
                default: rd_value = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rd_value;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_reg <= bfc_pkg::CTRL_RESET;
            cfg_addr_reg <= 23'h000000;
            wdata_reg <= 16'h0000;
        end else if (wr_access) begin
            if (paddr == bfc_pkg::OFF_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (paddr == bfc_pkg::OFF_ADDR) begin
                cfg_addr_reg <= pwdata[22:0]; // [R1]
            end
            if (paddr == bfc_pkg::OFF_WDATA) begin
                wdata_reg <= pwdata[15:0];
            end
        end
    end

    // Host-side copy of the 16-word write buffer, streamed in one burst.
    always_ff @(posedge clock) begin
        if (wr_access && ((paddr & bfc_pkg::BUF_MASK) == bfc_pkg::OFF_BUF)) begin
            buf_mem[paddr[5:2]] <= pwdata[15:0]; // [R5] [R6]
        end
    end

    // An operation is taken only when idle; it then waits for the wake time.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pend_reg <= 1'b0;
            kind_reg <= bfc_pkg::OP_WRITE;
            last_reg <= 4'h0;
        end else if (wr_access && paddr == bfc_pkg::OFF_OP && !busy) begin
            pend_reg <= 1'b1;
            kind_reg <= pwdata[bfc_pkg::OP_KIND_LSB +: 2];
            last_reg <= pwdata[bfc_pkg::OP_CNT_LSB +: 4];
        end else if (state_reg == bfc_pkg::S_IDLE && awake && reset_powerdown_n) begin
            pend_reg <= 1'b0; // [R21]
        end
    end

    // ----------------------------------------------------------------
    // Status output watch
    // ----------------------------------------------------------------
    // A completion pulse is a low-going edge; a clear in the same cycle loses.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sts_prev_reg <= 1'b0;
            pulse_seen_reg <= 1'b0;
        end else begin
            sts_prev_reg <= sts_sync;
            if (sts_prev_reg && !sts_sync) begin
                pulse_seen_reg <= 1'b1; // [R11] [R13]
            end else if (wr_access && paddr == bfc_pkg::OFF_STATUS
                         && pwdata[bfc_pkg::ST_PULSE]) begin
                pulse_seen_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus cycle sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= bfc_pkg::S_IDLE;
            cnt_reg <= 8'h00;
            idx_reg <= 4'h0;
            flash_addr <= 23'h000000;
            flash_dq_out <= 16'h0000;
            rdata_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                bfc_pkg::S_IDLE: begin
                    if (pend_reg && awake && reset_powerdown_n) begin
                        state_reg <= bfc_pkg::S_SETUP;
                        cnt_reg <= 8'(bfc_pkg::SETUP_CYC - 1);
                        idx_reg <= 4'h0;
                        // In x16 mode address bit zero is a don't care; drive it low.
                        flash_addr <= {cfg_addr_reg[22:1],
                            cfg_addr_reg[0] & !ctrl_reg[bfc_pkg::CTRL_X16]}; // [R15] [R16]
                        flash_dq_out <= (kind_reg == bfc_pkg::OP_BURST) ? buf_mem[0]
                            : wdata_reg; // [R4] [R7] [R8] [R9]
                    end
                end
                bfc_pkg::S_SETUP: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= bfc_pkg::S_STROBE;
                        cnt_reg <= is_write ? 8'(bfc_pkg::WE_CYC - 1)
                            : 8'(bfc_pkg::RD_CYC - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                bfc_pkg::S_STROBE: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= bfc_pkg::S_HOLD;
                        cnt_reg <= 8'(bfc_pkg::HOLD_CYC);
                        if (!is_write) begin
                            rdata_reg <= pin_sync[15:0] & {{8{flash_width_x16}}, 8'hff}; // [R15]
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                bfc_pkg::S_HOLD: begin
                    if (cnt_reg != 8'h00) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end else if (kind_reg == bfc_pkg::OP_BURST && idx_reg != last_reg) begin
                        state_reg <= bfc_pkg::S_SETUP;
                        cnt_reg <= 8'(bfc_pkg::SETUP_CYC - 1);
                        idx_reg <= idx_reg + 4'h1;
                        flash_addr <= ctrl_reg[bfc_pkg::CTRL_X16] ? flash_addr + 23'h000002
                            : flash_addr + 23'h000001;
                        flash_dq_out <= buf_mem[idx_reg + 4'h1]; // [R6]
                    end else if (kind_reg == bfc_pkg::OP_POLL
                                 && !rdata_reg[bfc_pkg::READY_BIT]) begin
                        state_reg <= bfc_pkg::S_SETUP; // [R24]
                        cnt_reg <= 8'(bfc_pkg::SETUP_CYC - 1);
                    end else begin
                        state_reg <= bfc_pkg::S_IDLE; // [R3] [R10]
                    end
                end
            endcase
        end
    end

    // Strobes and enables are flops so that the pins never glitch.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flash_ce <= bfc_pkg::CE_OFF;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_dq_oe <= 16'h0000;
            flash_width_x16 <= 1'b0;
            reset_powerdown_n <= 1'b0;
        end else begin
            reset_powerdown_n <= ctrl_reg[bfc_pkg::CTRL_RUN]; // [R18] [R19] [R22]
            flash_width_x16 <= ctrl_reg[bfc_pkg::CTRL_X16];
            // Deselecting between operations lets the device drop to standby.
            flash_ce <= (state_reg != bfc_pkg::S_IDLE) ? bfc_pkg::CE_ON
                : bfc_pkg::CE_OFF; // [R14] [R17] [R25]
            flash_we_n <= !(state_reg == bfc_pkg::S_STROBE && is_write); // [R2] [R23]
            flash_oe_n <= !(state_reg == bfc_pkg::S_STROBE && !is_write);
            flash_dq_oe <= (state_reg != bfc_pkg::S_IDLE && is_write)
                ? (ctrl_reg[bfc_pkg::CTRL_X16] ? 16'hffff : 16'h00ff) : 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_write_wake_gate: assert property (@(posedge clock) disable iff (reset) // [R21]
        !flash_we_n |-> reset_powerdown_n && wake_done)
        else $error("write strobe before wake time");
    a_read_recovery: assert property (@(posedge clock) disable iff (reset) // [R20]
        $fell(flash_oe_n) |-> out_done)
        else $error("read strobe before output recovery time");
    a_strobe_length: assert property (@(posedge clock) disable iff (reset) // [R23]
        $fell(flash_we_n) |-> !flash_we_n [*7] ##1 flash_we_n)
        else $error("write strobe length wrong");
    a_latch_stable: assert property (@(posedge clock) disable iff (reset) // [R23]
        $rose(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
        else $error("address or data moved at strobe rise");
    a_chip_selected: assert property (@(posedge clock) disable iff (reset) // [R14]
        (!flash_we_n || !flash_oe_n) |-> flash_ce == bfc_pkg::CE_ON)
        else $error("strobe without chip select");
    a_word_addr_lsb: assert property (@(posedge clock) disable iff (reset) // [R16]
        (!flash_we_n && flash_width_x16) |-> !flash_addr[0])
        else $error("address bit zero driven in x16 mode");
    a_byte_lane: assert property (@(posedge clock) disable iff (reset) // [R15]
        !flash_width_x16 && $stable(flash_width_x16) |-> flash_dq_oe[15:8] == 8'h00)
        else $error("high byte driven in x8 mode");
    a_poll_repeat: assert property (@(posedge clock) disable iff (reset) // [R24]
        (state_reg == bfc_pkg::S_HOLD && cnt_reg == 8'h00 && kind_reg == bfc_pkg::OP_POLL
         && !rdata_reg[bfc_pkg::READY_BIT]) |=> state_reg == bfc_pkg::S_SETUP)
        else $error("poll ended before ready bit set");
    a_pulse_sticky: assert property (@(posedge clock) disable iff (reset) // [R13]
        (sts_prev_reg && !sts_sync) |=> pulse_seen_reg)
        else $error("completion pulse not held");
    a_reset_quiet: assert property (@(posedge clock) disable iff (reset) // [R18]
        !reset_powerdown_n |=> flash_we_n && flash_oe_n)
        else $error("strobe while device held in reset");
endmodule
`default_nettype wire

/* verification/bfc_flash_model.sv */
// Behavioural parallel flash device that answers the host controller's pins.
`default_nettype none
module bfc_flash_model #(
    parameter int unsigned BUSY_NS = 2000,
    parameter logic [7:0] CMD_PROG = 8'h40,
    parameter logic [7:0] CMD_ARRAY = 8'hff
) (
    input wire logic [22:0] addr,
    input wire logic [15:0] dq,
    input wire logic [2:0] ce,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic width_x16,
    input wire logic reset_powerdown_n,
    output logic [15:0] dq_dev,
    output logic [15:0] dq_en,
    output logic sts_low
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [256];
    logic prog_next = 1'b0;
    logic busy = 1'b0;
    logic stat_mode = 1'b0;
    logic [7:0] w;
    logic sel;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    assign w = addr[8:1];
    assign sel = reset_powerdown_n && ce == bfc_pkg::CE_ON;
    assign sts_low = busy;
    always @(negedge reset_powerdown_n) begin
        busy = 1'b0;
        prog_next = 1'b0;
        stat_mode = 1'b0;
    end
    always @(posedge busy) begin
        #(BUSY_NS);
        busy = 1'b0;
    end
    always @(posedge we_n) begin
        if (sel && !busy) begin
            if (prog_next) begin
                if (width_x16) mem[w] = dq;
                else if (addr[0]) mem[w][15:8] = dq[7:0];
                else mem[w][7:0] = dq[7:0];
                prog_next = 1'b0;
                stat_mode = 1'b1;
                busy = 1'b1;
            end else if (dq[7:0] == CMD_PROG) prog_next = 1'b1;
            else stat_mode = dq[7:0] != CMD_ARRAY;
        end
    end
    always @* begin
        dq_en = 16'h0000;
        dq_dev = 16'h0000;
        if (sel && !oe_n) begin
            if (busy) dq_en = 16'h0080;
            else if (stat_mode) begin
                dq_en = 16'h00ff;
                dq_dev = 16'h0080;
            end else begin
                dq_en = width_x16 ? 16'hffff : 16'h00ff;
                dq_dev = width_x16 ? mem[w] : (addr[0] ? mem[w] >> 8 : mem[w] & 16'h00ff);
            end
        end
    end
endmodule
`default_nettype wire

/* verification/block_flash_command_automation_test.sv */
// Self-checking bench for the flash host controller with a device model.
`default_nettype none
module block_flash_command_automation_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic reset, psel, penable, pwrite, pready, pslverr, status_output;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [22:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_oe, flash_dq_in, dq_dev, dq_en;
    logic [15:0] flt = 16'ha5c3;
    logic [2:0] flash_ce;
    logic flash_oe_n, flash_we_n, flash_width_x16, reset_powerdown_n, sts_low, er;
    int n_fail = 0;
    int checks = 0;
    logic [11:0] row_a [4] = '{bfc_pkg::OFF_ADDR, bfc_pkg::OFF_BUF, 12'h07c, 12'h800};
    logic [31:0] row_d [4] = '{32'hffffffff, 32'h1234abcd, 32'h0000ffff, 32'h1};
    logic [31:0] row_q [4] = '{32'h007fffff, 32'h0000abcd, 32'h0000ffff, 32'h0};
    logic row_e [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    bfc_host i_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce(flash_ce),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_width_x16(flash_width_x16),
        .reset_powerdown_n(reset_powerdown_n), .status_output(status_output));
    bfc_flash_model i_dev (.addr(flash_addr), .dq(flash_dq_in), .ce(flash_ce),
        .oe_n(flash_oe_n), .we_n(flash_we_n), .width_x16(flash_width_x16),
        .reset_powerdown_n(reset_powerdown_n), .dq_dev(dq_dev), .dq_en(dq_en), .sts_low(sts_low));
    // Undriven data lines show a pattern that flips every cycle.
    assign flash_dq_in = (flash_dq_oe & flash_dq_out) | (dq_en & dq_dev)
        | (~flash_dq_oe & ~dq_en & flt);
    assign status_output = ~sts_low;
    always #2.5 clock = ~clock;
    always @(posedge clock) flt <= ~flt;
    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_bit(input int b, input logic v);
        do bus(1'b0, bfc_pkg::OFF_STATUS, 32'h0); while (rd[b] !== v);
    endtask
    task automatic flash_op(input logic [1:0] k, input logic [22:0] a, input logic [15:0] d);
        bus(1'b1, bfc_pkg::OFF_ADDR, {9'h0, a});
        bus(1'b1, bfc_pkg::OFF_WDATA, {16'h0, d});
        bus(1'b1, bfc_pkg::OFF_OP, {30'h0, k});
        repeat (2) @(posedge clock);
        wait_bit(bfc_pkg::ST_BUSY, 1'b0);
    endtask
    task automatic give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} <= {4'h8, 44'h0};
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk(flash_ce, bfc_pkg::CE_OFF);
        chk(reset_powerdown_n, 1'b0);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, row_a[i], row_d[i]);
            bus(1'b0, row_a[i], 32'h0);
            chk(er, row_e[i]);
            if (!row_e[i]) chk(rd, row_q[i]);
        end
        bus(1'b1, bfc_pkg::OFF_WDATA, 32'h70);
        bus(1'b1, bfc_pkg::OFF_OP, 32'h0);
        repeat (40) @(posedge clock);
        chk(flash_ce, bfc_pkg::CE_OFF);
        bus(1'b0, bfc_pkg::OFF_STATUS, 32'h0);
        chk(rd[3:1], 3'h1);
        bus(1'b1, bfc_pkg::OFF_CTRL, 32'h1);
        wait_bit(bfc_pkg::ST_AWAKE, 1'b1);
        chk(reset_powerdown_n, 1'b1);
        wait_bit(bfc_pkg::ST_BUSY, 1'b0);
        flash_op(bfc_pkg::OP_WRITE, 23'h11, 16'h40);
        flash_op(bfc_pkg::OP_WRITE, 23'h11, 16'h5a);
        bus(1'b0, bfc_pkg::OFF_STATUS, 32'h0);
        chk(rd[bfc_pkg::ST_LEVEL], 1'b0);
        flash_op(bfc_pkg::OP_POLL, 23'h11, 16'h0);
        bus(1'b0, bfc_pkg::OFF_RDATA, 32'h0);
        chk(rd[7], 1'b1);
        bus(1'b0, bfc_pkg::OFF_STATUS, 32'h0);
        chk(rd[2:1], 2'h3);
        bus(1'b1, bfc_pkg::OFF_STATUS, 32'h4);
        bus(1'b0, bfc_pkg::OFF_STATUS, 32'h0);
        chk(rd[bfc_pkg::ST_PULSE], 1'b0);
        flash_op(bfc_pkg::OP_WRITE, 23'h11, 16'hff);
        flash_op(bfc_pkg::OP_READ, 23'h11, 16'h0);
        bus(1'b0, bfc_pkg::OFF_RDATA, 32'h0);
        chk(rd, 32'h5a);
        flash_op(bfc_pkg::OP_READ, 23'h10, 16'h0);
        bus(1'b0, bfc_pkg::OFF_RDATA, 32'h0);
        chk(rd, 32'hff);
        bus(1'b1, bfc_pkg::OFF_CTRL, 32'h3);
        flash_op(bfc_pkg::OP_WRITE, 23'h21, 16'h40);
        flash_op(bfc_pkg::OP_WRITE, 23'h21, 16'hbeef);
        chk({flash_width_x16, flash_addr[0]}, 2'h2);
        flash_op(bfc_pkg::OP_POLL, 23'h21, 16'h0);
        flash_op(bfc_pkg::OP_WRITE, 23'h20, 16'hff);
        flash_op(bfc_pkg::OP_READ, 23'h21, 16'h0);
        bus(1'b0, bfc_pkg::OFF_RDATA, 32'h0);
        chk(rd, 32'hbeef);
        flash_op(bfc_pkg::OP_WRITE, 23'h0, 16'h40);
        flash_op(bfc_pkg::OP_WRITE, 23'h0, 16'h1234);
        bus(1'b1, bfc_pkg::OFF_CTRL, 32'h2);
        repeat (10) @(posedge clock);
        bus(1'b0, bfc_pkg::OFF_STATUS, 32'h0);
        chk(rd[3:1], 3'h3);
        bus(1'b1, bfc_pkg::OFF_CTRL, 32'h3);
        wait_bit(bfc_pkg::ST_AWAKE, 1'b1);
        flash_op(bfc_pkg::OP_READ, 23'h20, 16'h0);
        bus(1'b0, bfc_pkg::OFF_RDATA, 32'h0);
        chk(rd, 32'hbeef);
        bus(1'b1, bfc_pkg::OFF_CTRL, 32'h1);
        flash_op(bfc_pkg::OP_READ, 23'h20, 16'h0);
        bus(1'b0, bfc_pkg::OFF_RDATA, 32'h0);
        chk(rd, 32'hef);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk({flash_ce, reset_powerdown_n}, {bfc_pkg::CE_OFF, 1'b0});
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
